// File: logic/cbt_consts.vh
// Purpose: constants for the CAN bit timing and object irq enable block
// Assumes: byte-wide special-function register port, one 20 MHz clock
// Notes: offsets are the register addresses on the sfr port
// How it works
// (RL1) object_irq_mask sits in bits 3..0 of the enable register, 1 enables, all clear at reset.
// (RL2) the quantum period is the input clock divided by quantum_prescaler plus one, field in bits 6..1.
// (RL3) software touches the timing registers only while controller_global_enable is 0.
// (RL4) resync on relevant edges moves a bit by at most resync_jump_width quanta, field in bits 6..5; the code moves it by up to (resync_jump_width + 1) quanta.
// (RL5) propagation segment lasts (propagation_segment + 1) quanta, field in bits 3..1.
// (RL6) reserved bits read undefined and software never writes ones there.
// (RL7) timing registers have no reset value so software programs them before enabling.
// (RL8) phase segment two lasts (field + 1) quanta, bits 6..4, and may be shortened by resync.
// (RL9) phase segment one lasts (field + 1) quanta, bits 3..1, and may be lengthened by resync.
// (RL10) sample_type 0 samples once, 1 takes three samples half a quantum apart by majority; the code takes the first two a whole quantum apart.
// (RL11) a bit is sync quantum, propagation, phase one, phase two; sample at end of phase one.
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH
`define CBT_ADDR_PRESCALER   8'hB4
`define CBT_ADDR_JUMP_PROP   8'hB5
`define CBT_ADDR_PHASE_SMP   8'hB6
`define CBT_ADDR_IRQ_ENABLE  8'hC3
`define CBT_IRQ_MASK_RESET   4'h0
`define CBT_BRP_LSB          1
`define CBT_SJW_LSB          5
`define CBT_PRS_LSB          1
`define CBT_PHS2_LSB         4
`define CBT_PHS1_LSB         1
`define CBT_SMP_BIT          0
`endif

// File: logic/cbt_quantum_gen.v
// Purpose: time quantum and half quantum enable pulses
// Assumes: prescaler value steady while the controller runs
// Notes: half pulse lands mid quantum for triple sampling
`timescale 1ns/1ps
module cbt_quantum_gen
(
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       run,
  input  wire [5:0] prescale,
  output reg        tq_pulse,
  output reg        half_pulse
);
  reg  [6:0] cnt_r;
  wire [6:0] last;
  assign last = {1'b0, prescale};

  always @(posedge clk_sys)
  begin
    if (!resetn || !run)
    begin
      cnt_r      <= 7'h00;
      tq_pulse   <= 1'b0;
      half_pulse <= 1'b0;
    end
    else
    begin
      // quantum is prescale+1 input clocks
      tq_pulse   <= (cnt_r == last); // RL2
      half_pulse <= (cnt_r == {1'b0, last[6:1]});
      if (cnt_r == last)
        cnt_r <= 7'h00;
      else
        cnt_r <= cnt_r + 7'h01;
    end
  end
endmodule // cbt_quantum_gen

// File: logic/cbt_bit_timing.v
// Purpose: bit timing registers, bit segment sequencer, object irq mask
// Assumes: sfr port on clk_sys, rx pin asynchronous, one clock
// Notes: timing regs have no reset; undefined reserved bits read zero
`timescale 1ns/1ps
`include "cbt_consts.vh"
module cbt_bit_timing
(
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       controller_global_enable,
  input  wire       can_rx,
  output reg        sample_pulse,
  output reg        sampled_bit,
  output reg        bit_start,
  output reg  [3:0] object_irq_mask
);
  localparam [3:0] ST_SYNC = 4'h1;
  localparam [3:0] ST_PROP = 4'h2;
  localparam [3:0] ST_PH1  = 4'h4;
  localparam [3:0] ST_PH2  = 4'h8;

  // no reset on these: contents undefined until software writes them
  reg  [5:0] quantum_prescaler_r;
  reg  [1:0] resync_jump_width_r;
  reg  [2:0] propagation_segment_r;
  reg  [2:0] phase_segment_one_r;
  reg  [2:0] phase_segment_two_r;
  reg        sample_type_r;
  reg  [3:0] state_r;
  reg  [4:0] seg_cnt_r;
  reg  [4:0] seg_len_r;
  reg        rx_m_r;
  reg        rx_s_r;
  reg        rx_prev_r;
  reg        smp_a_r;
  reg        smp_b_r;
  reg        en_m_r;
  reg        run_r;
  reg        edge_seen_r;
  wire       tq_pulse;
  wire       half_pulse;
  wire       fall_edge;
  wire [4:0] sjw_q;
  wire [4:0] ph2_len;

  // two-stage synchronisers; only the second stage feeds logic
  always @(posedge clk_sys)
  begin
    rx_m_r <= can_rx;
    rx_s_r <= rx_m_r;
    en_m_r <= controller_global_enable;
    run_r  <= en_m_r;
  end

  cbt_quantum_gen u_qgen
  (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .run        (run_r),
    .prescale   (quantum_prescaler_r),
    .tq_pulse   (tq_pulse),
    .half_pulse (half_pulse)
  );

  function [4:0] seg_q;
    input [2:0] field;
    begin
      seg_q = {2'b00, field} + 5'h01;
    end
  endfunction

  assign sjw_q   = {3'b000, resync_jump_width_r} + 5'h01;
  assign ph2_len = seg_q(phase_segment_two_r);
  assign fall_edge = rx_prev_r & ~rx_s_r;

  // register writes; software writes timing only with enable low
  always @(posedge clk_sys)
  begin
    if (sfr_wr && !run_r) // RL3
    begin
      if (sfr_addr == `CBT_ADDR_PRESCALER)
        quantum_prescaler_r <= sfr_wdata[`CBT_BRP_LSB +: 6]; // RL2 RL7
      else if (sfr_addr == `CBT_ADDR_JUMP_PROP)
      begin
        resync_jump_width_r   <= sfr_wdata[`CBT_SJW_LSB +: 2]; // RL4
        propagation_segment_r <= sfr_wdata[`CBT_PRS_LSB +: 3]; // RL5
      end
      else if (sfr_addr == `CBT_ADDR_PHASE_SMP)
      begin
        phase_segment_two_r <= sfr_wdata[`CBT_PHS2_LSB +: 3]; // RL8
        phase_segment_one_r <= sfr_wdata[`CBT_PHS1_LSB +: 3]; // RL9
        sample_type_r       <= sfr_wdata[`CBT_SMP_BIT];       // RL10
      end
    end
  end

  // irq mask is writable any time
  always @(posedge clk_sys)
  begin
    if (!resetn)
      object_irq_mask <= `CBT_IRQ_MASK_RESET; // RL1
    else if (sfr_wr && sfr_addr == `CBT_ADDR_IRQ_ENABLE)
      object_irq_mask <= sfr_wdata[3:0]; // RL1
  end

  // reads: reserved bits return zero, a legal undefined value
  always @(posedge clk_sys)
  begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == `CBT_ADDR_PRESCALER)
        sfr_rdata <= {1'b0, quantum_prescaler_r, 1'b0}; // RL6
      else if (sfr_addr == `CBT_ADDR_JUMP_PROP)
        sfr_rdata <= {1'b0, resync_jump_width_r, 1'b0,
                      propagation_segment_r, 1'b0}; // RL6
      else if (sfr_addr == `CBT_ADDR_PHASE_SMP)
        sfr_rdata <= {1'b0, phase_segment_two_r,
                      phase_segment_one_r, sample_type_r}; // RL6
      else if (sfr_addr == `CBT_ADDR_IRQ_ENABLE)
        sfr_rdata <= {4'h0, object_irq_mask}; // RL6
      else
        sfr_rdata <= 8'h00;
    end
  end

  // bit sequencer; edge seen in prop or phase two triggers resync, at prop end or at next tq
  always @(posedge clk_sys)
  begin
    if (!resetn || !run_r)
    begin
      state_r      <= ST_SYNC;
      seg_cnt_r    <= 5'h00;
      seg_len_r    <= 5'h01;
      rx_prev_r    <= 1'b1;
      edge_seen_r  <= 1'b0;
      smp_a_r      <= 1'b1;
      smp_b_r      <= 1'b1;
      sample_pulse <= 1'b0;
      sampled_bit  <= 1'b1;
      bit_start    <= 1'b0;
    end
    else
    begin
      rx_prev_r    <= rx_s_r;
      sample_pulse <= 1'b0;
      bit_start    <= 1'b0;
      // triple sampling: two earlier samples one quantum apart, each at mid quantum
      if (half_pulse && state_r == ST_PH1)
      begin
        smp_a_r <= smp_b_r;
        smp_b_r <= rx_s_r;
      end
      if (tq_pulse)
      begin
        seg_cnt_r <= seg_cnt_r + 5'h01;
        case (state_r)
          ST_SYNC:
          begin
            edge_seen_r <= 1'b0;
            bit_start   <= 1'b1;
            state_r     <= ST_PROP; // RL11
            seg_cnt_r   <= 5'h00;
            seg_len_r   <= seg_q(propagation_segment_r); // RL5
          end
          ST_PROP:
            if (seg_cnt_r + 5'h01 >= seg_len_r)
            begin
              state_r   <= ST_PH1; // RL11
              seg_cnt_r <= 5'h00;
              seg_len_r <= seg_q(phase_segment_one_r); // RL9
              if (edge_seen_r)
              begin
                // late edge: lengthen phase one by the whole jump width
                seg_len_r   <= seg_q(phase_segment_one_r) + sjw_q; // RL4
                edge_seen_r <= 1'b0;
              end
            end
          ST_PH1:
            if (seg_cnt_r + 5'h01 >= seg_len_r)
            begin
              sample_pulse <= 1'b1; // RL11
              if (sample_type_r)
                sampled_bit <= (smp_a_r & smp_b_r) | (smp_a_r & rx_s_r)
                               | (smp_b_r & rx_s_r); // RL10
              else
                sampled_bit <= rx_s_r; // RL10
              state_r     <= ST_PH2;
              seg_cnt_r   <= 5'h00;
              seg_len_r   <= ph2_len; // RL8
              edge_seen_r <= 1'b0;
            end
          ST_PH2:
            if (seg_cnt_r + 5'h01 >= seg_len_r)
              state_r <= ST_SYNC;
            else if (edge_seen_r)
            begin
              // early edge: cut phase two short, bounded by jump width
              edge_seen_r <= 1'b0;
              if (ph2_len - (seg_cnt_r + 5'h01) <= sjw_q)
                state_r <= ST_SYNC; // RL4 RL8
              else
                seg_len_r <= ph2_len - sjw_q; // RL4 RL8
            end
          default:
            state_r <= ST_SYNC;
        endcase
      end
      // placed last so a new edge beats a same-cycle clear
      if (fall_edge)
        edge_seen_r <= 1'b1;
    end
  end
endmodule // cbt_bit_timing

// File: tb/cbt_sva.sv
// Purpose: port checker for cbt_bit_timing
// Assumes: sync active low reset, one clock
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module cbt_sva
(
  input wire       clk_sys,
  input wire       resetn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       controller_global_enable,
  input wire       sample_pulse,
  input wire       bit_start,
  input wire [3:0] object_irq_mask
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_rst;
    $rose(resetn) |-> object_irq_mask == 4'h0 && sfr_rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_mwr;
    sfr_wr && sfr_addr == 8'hC3 |=>
      {4'h0, object_irq_mask} == ($past(sfr_wdata) & 8'h0F);
  endproperty
  a_mwr: assert property (p_mwr) else $error("mask not written");
  property p_rc3;
    sfr_rd && !sfr_wr && sfr_addr == 8'hC3 |=>
      sfr_rdata == {4'h0, object_irq_mask};
  endproperty
  a_rc3: assert property (p_rc3) else $error("mask read wrong");
  property p_rb4;
    sfr_rd && sfr_addr == 8'hB4 |=> (sfr_rdata & 8'h81) == 8'h00;
  endproperty
  a_rb4: assert property (p_rb4) else $error("b4 reserved set");
  property p_rb5;
    sfr_rd && sfr_addr == 8'hB5 |=> (sfr_rdata & 8'h91) == 8'h00;
  endproperty
  a_rb5: assert property (p_rb5) else $error("b5 reserved set");
  property p_rb6;
    sfr_rd && sfr_addr == 8'hB6 |=> !sfr_rdata[7];
  endproperty
  a_rb6: assert property (p_rb6) else $error("b6 reserved set");
  property p_unm;
    sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_off;
    !controller_global_enable [*4] |-> !bit_start && !sample_pulse;
  endproperty
  a_off: assert property (p_off) else $error("runs when off");
  property p_sep;
    bit_start |-> !sample_pulse;
  endproperty
  a_sep: assert property (p_sep) else $error("pulses overlap");
  c_mwr: cover property (sfr_wr && sfr_addr == 8'hC3);
  c_smp: cover property (sample_pulse);
  c_bit: cover property (bit_start ##1 !bit_start);
endmodule // cbt_sva
bind cbt_bit_timing cbt_sva chk (.clk_sys, .resetn, .sfr_addr, .sfr_wdata,
  .sfr_wr, .sfr_rd, .sfr_rdata, .controller_global_enable,
  .sample_pulse, .bit_start, .object_irq_mask);

// File: tb/cbt_can_node.sv
// Purpose: far node on the can bus
// Assumes: bench tells it when to pull dominant
// Notes: wired-and bus, recessive when released
`timescale 1ns/1ps
module cbt_can_node
(
  input  wire clk_sys,
  input  wire drive_dom,
  output reg  can_rx
);
  initial can_rx = 1'b1;
  always @(posedge clk_sys)
    can_rx <= #2 !drive_dom;
endmodule // cbt_can_node

// File: tb/tb_top.sv
// Purpose: self checking bench for cbt_bit_timing
// Assumes: inputs driven 2 ns after the rising edge
// Notes: reads checked from a queue one cycle later
`timescale 1ns/1ps
`include "cbt_consts.vh"
module tb_top;
  reg        clk_sys, resetn, sfr_wr, sfr_rd, cge, dom, rd_d, armed;
  reg  [7:0] sfr_addr, sfr_wdata, v;
  wire [7:0] sfr_rdata;
  wire       can_rx, sample_pulse, sampled_bit, bit_start;
  wire [3:0] object_irq_mask;
  integer    fail_count, cmp_count, seed, cnt, i;
  reg  [7:0] rq[$];
  integer    sq[$], pq[$];
  reg  [7:0] ad[0:3], mk[0:3];
  cbt_bit_timing dut (.clk_sys, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .controller_global_enable(cge), .can_rx,
    .sample_pulse, .sampled_bit, .bit_start, .object_irq_mask);
  cbt_can_node node (.clk_sys, .drive_dom(dom), .can_rx);
  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
    end
  endtask
  // strobes stay up; idle drops them, so no same-step double assign
  task acc(input wr, input [7:0] a, input [7:0] d);
    begin
      if (!wr) rq.push_back(d);
      sfr_wr = wr;
      sfr_rd = !wr;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge clk_sys);
      #2;
    end
  endtask
  task idle;
    begin
      sfr_wr = 0;
      sfr_rd = 0;
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // brp 1, prs 1, ph1 2, ph2 2: quantum 2 clocks
  task run(input s, input d);
    begin
      acc(1, `CBT_ADDR_PRESCALER, 8'h02);
      acc(1, `CBT_ADDR_JUMP_PROP, 8'h02);
      acc(1, `CBT_ADDR_PHASE_SMP, {4'h2, 3'h2, s});
      idle;
      dom = d;
      repeat (2) sq.push_back(10);
      repeat (2) pq.push_back(18);
      cge = 1;
      repeat (80) @(posedge clk_sys);
      #2;
      check(sampled_bit, !d);
      cge = 0;
      repeat (4) @(posedge clk_sys);
      #2;
      $display("end of timing run smp %0d", s);
    end
  endtask
  always @(posedge clk_sys)
  begin
    // strobe taken at this edge, data lands right after it
    rd_d = sfr_rd;
    #1;
    if (rd_d) check(sfr_rdata, rq.pop_front());
    cnt = cnt + 1;
    if (!cge) armed = 0;
    if (sample_pulse && armed && sq.size() > 0)
      check(cnt, sq.pop_front());
    if (bit_start)
    begin
      if (armed && pq.size() > 0) check(cnt, pq.pop_front());
      armed = cge;
      cnt = 0;
    end
  end
  initial
  begin
    #(50 * 20000);
    fail_count = fail_count + 1;
    complete_run;
  end
  initial
  begin
    {fail_count, cmp_count, cnt} = 0;
    seed = 32'h7AAD;
    {resetn, sfr_wr, sfr_rd, cge, dom, rd_d, armed} = 0;
    {sfr_addr, sfr_wdata} = 16'h0000;
    ad[0] = `CBT_ADDR_PRESCALER;
    ad[1] = `CBT_ADDR_JUMP_PROP;
    ad[2] = `CBT_ADDR_PHASE_SMP;
    ad[3] = `CBT_ADDR_IRQ_ENABLE;
    {mk[0], mk[1], mk[2], mk[3]} = 32'h7E6E7F0F;
    repeat (20) @(posedge clk_sys);
    #2;
    resetn = 1;
    check(object_irq_mask, 4'h0);
    acc(0, `CBT_ADDR_IRQ_ENABLE, 8'h00);
    acc(0, 8'h00, 8'h00);
    // controller off for all timing accesses
    for (i = 0; i < 12; i = i + 1)
    begin
      v = $random(seed) & mk[i % 4];
      acc(1, ad[i % 4], v);
      acc(0, ad[i % 4], v);
      if (i % 4 == 3) check(object_irq_mask, v[3:0]);
    end
    idle;
    repeat (2) @(posedge clk_sys);
    #2;
    $display("end of register test");
    acc(1, `CBT_ADDR_IRQ_ENABLE, 8'h0F);
    idle;
    check(object_irq_mask, 4'hF);
    resetn = 0;
    repeat (2) @(posedge clk_sys);
    #2;
    resetn = 1;
    check(object_irq_mask, 4'h0);
    $display("end of reset test");
    run(1'b0, 1'b1);
    run(1'b1, 1'b0);
    run(1'b1, 1'b1);
    complete_run;
  end
endmodule // tb_top
